// ### pkg/gpz_regs.svh
// Register offsets, field positions and reset values of the eight-pin port
`ifndef GPZ_REGS_SVH
`define GPZ_REGS_SVH

`define GPZ_ADDR_W           4
`define GPZ_DATA_W           8
`define GPZ_PINS             8

`define GPZ_OFF_LATCH        4'h0
`define GPZ_OFF_DIR          4'h1
`define GPZ_OFF_AIDR         4'h2
`define GPZ_OFF_CTRL         4'h3
`define GPZ_OFF_PANEL        4'h4

`define GPZ_CTRL_FLOAT_BIT   0
`define GPZ_CTRL_PANEL_BIT   1
`define GPZ_CTRL_MASK        8'h03

`define GPZ_SEG_PIN_MASK     8'hfe

`define GPZ_RST_LATCH        8'h00
`define GPZ_RST_DIR          8'h00
`define GPZ_RST_AIDR         8'h00
`define GPZ_RST_CTRL         8'h00
`define GPZ_RST_PANEL        8'h00
`define GPZ_RST_RDATA        8'h00

`endif

// ### pkg/gpz_pkg.sv
// Types shared by the port modules
package gpz_pkg;

   typedef enum logic [1:0] {
      GPZ_RUN   = 2'b00,
      GPZ_HOLD  = 2'b01,
      GPZ_FLOAT = 2'b10
   } gpz_standby_e;

endpackage

// ### rtl/gpz_sync.sv
// Two-stage synchroniser for the pin levels
`timescale 1ns/1ns
module gpz_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             mclk_in,
   input  wire logic             rst_n_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_one;

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stage_one <= '0;
         sync_out  <= '0;
      end else begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end

endmodule

// ### rtl/gpz_pin_mux.sv
// Per-pin choice of driver: port latch, peripheral, segment drive or float
`timescale 1ns/1ns
module gpz_pin_mux #(
   parameter int WIDTH = 8
) (
   input  wire logic [WIDTH-1:0] latch_in,
   input  wire logic [WIDTH-1:0] dir_in,
   input  wire logic [WIDTH-1:0] periph_oe_in,
   input  wire logic [WIDTH-1:0] periph_out_in,
   input  wire logic [WIDTH-1:0] seg_en_in,
   input  wire logic             float_in,
   output logic      [WIDTH-1:0] drv_out_out,
   output logic      [WIDTH-1:0] drv_oe_out
);

   always_comb begin
      // Segment drive takes the pin away from the port
      drv_oe_out  = (periph_oe_in | dir_in) & ~seg_en_in & {WIDTH{~float_in}};
      // Peripheral wins over the latch when its output is enabled
      drv_out_out = (periph_oe_in & periph_out_in) | (~periph_oe_in & latch_in);
   end

endmodule

// ### rtl/gpz_port.sv
// Eight-pin shared general-purpose port: registers, pin drive, input gating
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "gpz_regs.svh"

module gpz_port #(
   parameter int PINS = `GPZ_PINS
) (
   input  wire logic                   mclk_in,
   input  wire logic                   rst_n_in,
   input  wire logic [`GPZ_ADDR_W-1:0] reg_addr_in,
   input  wire logic [`GPZ_DATA_W-1:0] reg_wdata_in,
   input  wire logic                   reg_wr_in,
   input  wire logic                   reg_rd_in,
   input  wire logic                   reg_rmw_in,
   output logic      [`GPZ_DATA_W-1:0] reg_rdata_out,
   input  wire logic [PINS-1:0]        pin_in,
   output logic      [PINS-1:0]        pin_out,
   output logic      [PINS-1:0]        pin_oe_out,
   input  wire logic [PINS-1:0]        periph_oe_in,
   input  wire logic [PINS-1:0]        periph_out_in,
   input  wire logic [PINS-1:0]        ext_irq_en_in,
   input  wire logic                   standby_req_in,
   output logic      [PINS-1:0]        digital_in_out,
   output logic      [PINS-1:0]        ext_irq_level_out,
   output logic      [PINS-1:0]        analog_en_out,
   output logic      [PINS-1:0]        seg_en_out
);

   logic [PINS-1:0]        port_output_latch;
   logic [PINS-1:0]        port_direction;
   logic [PINS-1:0]        analog_input_disable_low;
   logic [`GPZ_DATA_W-1:0] ctrl;
   logic [PINS-1:0]        panel_drive_select;
   logic [PINS-1:0]        pin_sync;
   logic [PINS-1:0]        next_drv_out;
   logic [PINS-1:0]        next_drv_oe;
   logic [PINS-1:0]        seg_en;
   logic [PINS-1:0]        blocked;
   logic [PINS-1:0]        din_level;
   logic [PINS-1:0]        latch_view;
   logic [`GPZ_DATA_W-1:0] next_rdata;
   logic                   standby_pin_float;
   logic                   panel_port_input_control;
   gpz_pkg::gpz_standby_e  state_q;
   gpz_pkg::gpz_standby_e  next_state;

   function automatic logic reg_hit(input logic [`GPZ_ADDR_W-1:0] addr,
                                    input logic [`GPZ_ADDR_W-1:0] off);
      reg_hit = (addr == off);
   endfunction

   function automatic logic [`GPZ_DATA_W-1:0] widen(input logic [PINS-1:0] v);
      widen = `GPZ_DATA_W'(v);
   endfunction

   assign standby_pin_float        = ctrl[`GPZ_CTRL_FLOAT_BIT];
   assign panel_port_input_control = ctrl[`GPZ_CTRL_PANEL_BIT];

   gpz_sync #(
      .WIDTH (PINS)
   ) u_sync (
      .mclk_in  (mclk_in),
      .rst_n_in (rst_n_in),
      .async_in (pin_in),
      .sync_out (pin_sync)
   );

   // Latch keeps its value whatever the direction; direction gates the driver and the latch read, not the latch
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         port_output_latch <= PINS'(`GPZ_RST_LATCH);
      end else if (reg_wr_in && reg_hit(reg_addr_in, `GPZ_OFF_LATCH)) begin
         port_output_latch <= reg_wdata_in[PINS-1:0];
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         port_direction <= PINS'(`GPZ_RST_DIR);
      end else if (reg_wr_in && reg_hit(reg_addr_in, `GPZ_OFF_DIR)) begin
         port_direction <= reg_wdata_in[PINS-1:0];
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         analog_input_disable_low <= PINS'(`GPZ_RST_AIDR);
      end else if (reg_wr_in && reg_hit(reg_addr_in, `GPZ_OFF_AIDR)) begin
         analog_input_disable_low <= reg_wdata_in[PINS-1:0];
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl <= `GPZ_RST_CTRL;
      end else if (reg_wr_in && reg_hit(reg_addr_in, `GPZ_OFF_CTRL)) begin
         ctrl <= reg_wdata_in & `GPZ_CTRL_MASK;
      end
   end

   // Pin 0 has no segment function, so its select bit is stuck at zero
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         panel_drive_select <= PINS'(`GPZ_RST_PANEL);
      end else if (reg_wr_in && reg_hit(reg_addr_in, `GPZ_OFF_PANEL)) begin
         panel_drive_select <= reg_wdata_in[PINS-1:0] & PINS'(`GPZ_SEG_PIN_MASK);
      end
   end

   // Segment drive only once the input control bit confirms the selection
   assign seg_en = panel_drive_select & {PINS{panel_port_input_control}};

   // Float mode chosen at standby entry and kept until standby ends
   always_comb begin
      next_state = state_q;
      unique case (state_q)
         gpz_pkg::GPZ_RUN: begin
            if (standby_req_in) begin
               next_state = standby_pin_float ? gpz_pkg::GPZ_FLOAT : gpz_pkg::GPZ_HOLD;
            end
         end
         gpz_pkg::GPZ_HOLD,
         gpz_pkg::GPZ_FLOAT: begin
            if (!standby_req_in) begin
               next_state = gpz_pkg::GPZ_RUN;
            end
         end
         default: begin
            next_state = gpz_pkg::GPZ_RUN;
         end
      endcase
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= gpz_pkg::GPZ_RUN;
      end else begin
         state_q <= next_state;
      end
   end

   gpz_pin_mux #(
      .WIDTH (PINS)
   ) u_mux (
      .latch_in      (port_output_latch),
      .dir_in        (port_direction),
      .periph_oe_in  (periph_oe_in),
      .periph_out_in (periph_out_in),
      .seg_en_in     (seg_en),
      .float_in      (state_q == gpz_pkg::GPZ_FLOAT),
      .drv_out_out   (next_drv_out),
      .drv_oe_out    (next_drv_oe)
   );

   // Hold state freezes the pads so levels survive the standby
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_out    <= '0;
         pin_oe_out <= '0;
      end else if (state_q != gpz_pkg::GPZ_HOLD) begin
         pin_out    <= next_drv_out;
         pin_oe_out <= next_drv_oe;
      end
   end

   // Input forced low in float mode to stop leakage, unless the interrupt needs it
   assign blocked   = {PINS{state_q == gpz_pkg::GPZ_FLOAT}} & ~ext_irq_en_in;
   assign din_level = pin_sync & analog_input_disable_low & ~blocked;

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         digital_in_out    <= '0;
         ext_irq_level_out <= '0;
         analog_en_out     <= '0;
         seg_en_out        <= '0;
      end else begin
         digital_in_out    <= din_level;
         ext_irq_level_out <= pin_sync & ~blocked;
         analog_en_out     <= ~port_direction & ~analog_input_disable_low;
         seg_en_out        <= seg_en & ~port_direction;
      end
   end

   // Latch seen for output-port pins and for every read-modify-write read
   assign latch_view = (port_direction & ~periph_oe_in & ~seg_en) | {PINS{reg_rmw_in}};

   always_comb begin
      next_rdata = '0;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            `GPZ_OFF_LATCH: begin
               next_rdata = widen((latch_view & port_output_latch) |
                                  (~latch_view & din_level));
            end
            `GPZ_OFF_DIR:   next_rdata = widen(port_direction);
            `GPZ_OFF_AIDR:  next_rdata = widen(analog_input_disable_low);
            `GPZ_OFF_CTRL:  next_rdata = ctrl;
            `GPZ_OFF_PANEL: next_rdata = widen(panel_drive_select);
            default:        next_rdata = '0;
         endcase
      end
   end

   // Read data stand for exactly one cycle after the strobe
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= `GPZ_RST_RDATA;
      end else begin
         reg_rdata_out <= next_rdata;
      end
   end

   // Checks
   logic first_q;

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         first_q <= 1'b1;
      end else begin
         first_q <= 1'b0;
      end
   end

   default clocking cb @(posedge mclk_in);
   endclocking

   default disable iff (!rst_n_in);

   logic [PINS-1:0] port_drv;
   assign port_drv = port_direction & ~periph_oe_in & ~seg_en;

   chk_out_drives_latch: assert property (
      (state_q == gpz_pkg::GPZ_RUN && !standby_req_in) |=>
         ((pin_oe_out & $past(port_drv)) == $past(port_drv)) &&
         (((pin_out ^ $past(port_output_latch)) & $past(port_drv)) == '0))
      else $error("output port pin not driving its latch bit");

   chk_write_reaches_pin: assert property (
      (reg_wr_in && reg_addr_in == `GPZ_OFF_LATCH && state_q == gpz_pkg::GPZ_RUN &&
       !standby_req_in && port_drv == {PINS{1'b1}} && $stable(port_direction)) |=>
         ##1 (state_q != gpz_pkg::GPZ_RUN || pin_out == $past(reg_wdata_in[PINS-1:0], 2)))
      else $error("latch write did not reach output pins two cycles later");

   chk_input_undriven: assert property (
      (state_q == gpz_pkg::GPZ_RUN) |=>
         ((pin_oe_out & $past(~port_direction & ~periph_oe_in)) == '0))
      else $error("input pin driven");

   chk_read_latch_out: assert property (
      (reg_rd_in && !reg_rmw_in && reg_addr_in == `GPZ_OFF_LATCH) |=>
         ((reg_rdata_out[PINS-1:0] & $past(port_drv)) ==
          ($past(port_output_latch) & $past(port_drv))))
      else $error("output pin read did not return latch");

   chk_read_rmw_latch: assert property (
      (reg_rd_in && reg_rmw_in && reg_addr_in == `GPZ_OFF_LATCH) |=>
         (reg_rdata_out == widen($past(port_output_latch))))
      else $error("read-modify-write read did not return latch");

   chk_read_pin_level: assert property (
      (reg_rd_in && !reg_rmw_in && reg_addr_in == `GPZ_OFF_LATCH) |=>
         ((reg_rdata_out[PINS-1:0] & ~$past(port_drv)) ==
          ($past(pin_sync & analog_input_disable_low & ~blocked) & ~$past(port_drv))))
      else $error("input pin read did not return pin level");

   chk_aidr_gates_in: assert property (
      ##1 ((digital_in_out & ~$past(analog_input_disable_low)) == '0))
      else $error("digital input passed with analog disable bit clear");

   chk_reset_clears: assert property (
      first_q |-> (port_direction == '0) && (analog_input_disable_low == '0) &&
                  (pin_oe_out == '0))
      else $error("direction or analog disable not cleared by reset");

   chk_float_hiz: assert property (
      (state_q == gpz_pkg::GPZ_FLOAT) |=>
         (pin_oe_out == '0) && ((digital_in_out & ~$past(ext_irq_en_in)) == '0))
      else $error("float standby left a pin driven or input open");

   chk_hold_levels: assert property (
      (state_q == gpz_pkg::GPZ_HOLD) |=> $stable(pin_oe_out) && $stable(pin_out))
      else $error("hold standby changed pin levels");

   chk_standby_entry: assert property (
      (state_q == gpz_pkg::GPZ_RUN && standby_req_in) |=>
         (state_q == (($past(standby_pin_float)) ? gpz_pkg::GPZ_FLOAT : gpz_pkg::GPZ_HOLD)))
      else $error("wrong standby state chosen");

   chk_irq_feed: assert property (
      (state_q != gpz_pkg::GPZ_FLOAT) |=> (ext_irq_level_out == $past(pin_sync)))
      else $error("pin level not fed to interrupt logic");

   chk_dir_bit_map: assert property (
      (reg_wr_in && reg_addr_in == `GPZ_OFF_DIR) |=>
         (port_direction == $past(reg_wdata_in[PINS-1:0])))
      else $error("direction bits not mapped to pins");

   cov_rmw_read:  cover property (reg_rd_in && reg_rmw_in && reg_addr_in == `GPZ_OFF_LATCH);
   cov_float:     cover property (state_q == gpz_pkg::GPZ_FLOAT ##1 state_q == gpz_pkg::GPZ_RUN);
   cov_hold:      cover property (state_q == gpz_pkg::GPZ_HOLD);
   cov_analog:    cover property (analog_en_out != '0);
   cov_segment:   cover property (seg_en_out != '0);

endmodule

// ### tb/gpz_pad_model.sv
// Pad and board model: resolves each pin from the port drive and the outside drive
`timescale 1ns/1ns
module gpz_pad_model #(
   parameter int PINS = 8
) (
   input  wire logic            mclk_in,
   input  wire logic [PINS-1:0] pin_out_in,
   input  wire logic [PINS-1:0] pin_oe_in,
   input  wire logic [PINS-1:0] ext_val_in,
   input  wire logic            ext_en_in,
   output logic      [PINS-1:0] pin_level_out
);
   logic [PINS-1:0] churn;

   // No pull on these pads: an open pin must not look like a stable level
   initial churn = 8'h55;
   always @(posedge mclk_in) churn <= ~churn;

   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         if (pin_oe_in[i]) begin
            pin_level_out[i] = pin_out_in[i];
         end else if (ext_en_in) begin
            pin_level_out[i] = ext_val_in[i];
         end else begin
            pin_level_out[i] = churn[i];
         end
      end
   end
endmodule

// ### tb/test_gpz_port.sv
// Self-checking bench for the eight-pin shared port
`timescale 1ns/1ns
`include "gpz_regs.svh"
module test_gpz_port;
   logic       mclk_in, rst_n_in, wr, rd, rmw, standby, ext_en;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, pin_level, pin_out, pin_oe, periph_oe, periph_out;
   logic [7:0] irq_en, din, irq_lvl, ana_en, seg_en, ext_val;
   int         num_errors, n_tests;

   gpz_port u_dut (
      .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rmw_in(rmw), .reg_rdata_out(rdata),
      .pin_in(pin_level), .pin_out(pin_out), .pin_oe_out(pin_oe),
      .periph_oe_in(periph_oe), .periph_out_in(periph_out), .ext_irq_en_in(irq_en),
      .standby_req_in(standby), .digital_in_out(din), .ext_irq_level_out(irq_lvl),
      .analog_en_out(ana_en), .seg_en_out(seg_en)
   );

   gpz_pad_model u_pads (
      .mclk_in(mclk_in), .pin_out_in(pin_out), .pin_oe_in(pin_oe),
      .ext_val_in(ext_val), .ext_en_in(ext_en), .pin_level_out(pin_level)
   );

   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk_in);
      wr <= 1'b0;
   endtask

   // Data stands only in the cycle after the strobe, so sample just past that edge
   task automatic rd_chk(input string name, input logic [3:0] a, input logic m,
                         input logic [7:0] exp);
      @(posedge mclk_in);
      addr <= a;
      rmw  <= m;
      rd   <= 1'b1;
      @(posedge mclk_in);
      rd  <= 1'b0;
      rmw <= 1'b0;
      #1 chk(name, rdata, exp);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic t_reset;
      rst_n_in <= 1'b0;
      cyc(10);
      rst_n_in <= 1'b1;
      cyc(2);
      chk("analog_en", ana_en, 8'hff);
      chk("pin_oe", pin_oe, 8'h00);
      rd_chk("dir", `GPZ_OFF_DIR, 1'b0, 8'h00);
      rd_chk("aidr", `GPZ_OFF_AIDR, 1'b0, 8'h00);
      rd_chk("unmapped", 4'hf, 1'b0, 8'h00);
   endtask

   task automatic t_output;
      wr_reg(`GPZ_OFF_AIDR, 8'hff);
      wr_reg(`GPZ_OFF_DIR, 8'hff);
      wr_reg(`GPZ_OFF_LATCH, 8'ha5);
      cyc(2);
      chk("pin_oe", pin_oe, 8'hff);
      chk("pin_out", pin_out, 8'ha5);
      rd_chk("latch", `GPZ_OFF_LATCH, 1'b0, 8'ha5);
      for (int k = 0; k < 8; k++) begin
         wr_reg(`GPZ_OFF_LATCH, 8'h01 << k);
         cyc(2);
         chk("walk", pin_out, 8'h01 << k);
      end
   endtask

   task automatic t_input;
      ext_val <= 8'h3c;
      ext_en  <= 1'b1;
      wr_reg(`GPZ_OFF_DIR, 8'h0f);
      wr_reg(`GPZ_OFF_LATCH, 8'h5a);
      cyc(2);
      chk("pin_oe", pin_oe, 8'h0f);
      chk("pin_out", pin_out & 8'h0f, 8'h0a);
      cyc(3);
      rd_chk("pin_read", `GPZ_OFF_LATCH, 1'b0, 8'h3a);
      rd_chk("rmw_read", `GPZ_OFF_LATCH, 1'b1, 8'h5a);
      wr_reg(`GPZ_OFF_AIDR, 8'h0f);
      cyc(4);
      rd_chk("gated", `GPZ_OFF_LATCH, 1'b0, 8'h0a);
      chk("digital_in", din, 8'h0a);
      chk("analog_en", ana_en, 8'hf0);
      chk("irq_level", irq_lvl, 8'h3a);
   endtask

   task automatic t_periph;
      wr_reg(`GPZ_OFF_AIDR, 8'hff);
      wr_reg(`GPZ_OFF_DIR, 8'hff);
      periph_out <= 8'hc0;
      periph_oe  <= 8'hf0;
      cyc(5);
      chk("pin_out", pin_out, 8'hca);
      rd_chk("pin_read", `GPZ_OFF_LATCH, 1'b0, 8'hca);
      rd_chk("rmw_read", `GPZ_OFF_LATCH, 1'b1, 8'h5a);
      @(posedge mclk_in);
      periph_oe <= 8'h00;
   endtask

   task automatic t_segment;
      wr_reg(`GPZ_OFF_DIR, 8'h00);
      wr_reg(`GPZ_OFF_PANEL, 8'h07);
      wr_reg(`GPZ_OFF_CTRL, 8'h02);
      cyc(2);
      chk("seg_en", seg_en, 8'h06);
      rd_chk("panel", `GPZ_OFF_PANEL, 1'b0, 8'h06);
      wr_reg(`GPZ_OFF_DIR, 8'h02);
      cyc(2);
      chk("seg_dir", seg_en, 8'h04);
      chk("seg_hiz", pin_oe, 8'h00);
      wr_reg(`GPZ_OFF_PANEL, 8'h00);
      cyc(2);
      chk("port_back", seg_en, 8'h00);
      chk("port_oe", pin_oe, 8'h02);
      wr_reg(`GPZ_OFF_CTRL, 8'h00);
   endtask

   task automatic t_standby;
      wr_reg(`GPZ_OFF_CTRL, 8'h01);
      wr_reg(`GPZ_OFF_DIR, 8'hff);
      ext_val <= 8'hff;
      irq_en  <= 8'h01;
      standby <= 1'b1;
      cyc(3);
      chk("float_oe", pin_oe, 8'h00);
      cyc(4);
      chk("float_irq", irq_lvl, 8'h01);
      chk("float_din", din, 8'h01);
      standby <= 1'b0;
      cyc(4);
      chk("resume_oe", pin_oe, 8'hff);
      wr_reg(`GPZ_OFF_CTRL, 8'h00);
      wr_reg(`GPZ_OFF_LATCH, 8'h3c);
      cyc(2);
      standby <= 1'b1;
      cyc(3);
      wr_reg(`GPZ_OFF_LATCH, 8'hc3);
      cyc(3);
      chk("hold_out", pin_out, 8'h3c);
      chk("hold_oe", pin_oe, 8'hff);
      standby <= 1'b0;
      cyc(4);
      chk("after_hold", pin_out, 8'hc3);
   endtask

   initial begin
      rst_n_in   = 1'b0;
      {wr, rd, rmw, standby, ext_en} = 5'h00;
      {addr, wdata, periph_oe, periph_out, irq_en, ext_val} = '0;
      num_errors = 0;
      n_tests    = 0;
      t_reset();
      t_output();
      t_input();
      t_periph();
      t_segment();
      t_standby();
      // Reset again mid-run with non-default register contents
      t_reset();
      tally_and_finish();
   end

   initial begin
      cyc(100000);
      num_errors++;
      tally_and_finish();
   end
endmodule
